/* ddsl_loader.v */
/*
 Serial word loader of a dual 10-bit DAC: frame select, shift clock and
 data pins are oversampled by mclk_i, words are decoded into the channel
 latches, holding buffer and control register, and an AXI4-Lite slave
 lets software read back the latched state.
 Assumes mclk_i is at least four times the shift clock rate.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ddsl_consts.vh"
module ddsl_loader (
	input wire mclk_i,
	input wire rst_i,
	input wire frame_n_i,
	input wire shift_clk_i,
	input wire serial_data_i,
	input wire [3:0] s_axi_awaddr_i,
	input wire s_axi_awvalid_i,
	output reg s_axi_awready_o,
	input wire [31:0] s_axi_wdata_i,
	input wire [3:0] s_axi_wstrb_i,
	input wire s_axi_wvalid_i,
	output reg s_axi_wready_o,
	output reg [1:0] s_axi_bresp_o,
	output reg s_axi_bvalid_o,
	input wire s_axi_bready_i,
	input wire [3:0] s_axi_araddr_i,
	input wire s_axi_arvalid_i,
	output reg s_axi_arready_o,
	output reg [31:0] s_axi_rdata_o,
	output reg [1:0] s_axi_rresp_o,
	output reg s_axi_rvalid_o,
	input wire s_axi_rready_i,
	output reg [9:0] channel_a_out_o,
	output reg [9:0] channel_b_out_o,
	output reg speed_sel_o,
	output reg powerdown_sel_o,
	output reg vref_sel_hi_o,
	output reg vref_sel_lo_o,
	output reg word_done_o
);
	localparam ST_IDLE = 2'b00;
	localparam ST_SHIFT = 2'b01;
	localparam ST_WAIT = 2'b10;

	function [31:0] ddsl_read_mux;
		input [3:0] addr;
		input [9:0] code_a;
		input [9:0] code_b;
		input [9:0] code_h;
		input [31:0] status;
		begin
			case (addr)
			`DDSL_ADDR_STATUS: ddsl_read_mux = status;
			`DDSL_ADDR_CHAN_A: ddsl_read_mux = {22'h000000, code_a};
			`DDSL_ADDR_CHAN_B: ddsl_read_mux = {22'h000000, code_b};
			`DDSL_ADDR_HOLD: ddsl_read_mux = {22'h000000, code_h};
			default: ddsl_read_mux = 32'h0000_0000;
			endcase
		end
	endfunction

	function ddsl_addr_ok;
		input [3:0] addr;
		begin
			ddsl_addr_ok = (addr[1:0] == 2'b00);
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers and edge detection

	wire [2:0] pins;
	reg frame_n_d;
	reg shift_clk_d;
	reg [1:0] state;
	reg [1:0] next_state;
	reg [15:0] shift_word;
	reg [4:0] bit_count;
	reg [9:0] hold_code;
	reg frame_err;
	reg [7:0] word_count;
	reg soft_clear;

	ddsl_sync #(
		.WIDTH(3)
	) u_sync (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.async_i({frame_n_i, shift_clk_i, serial_data_i}),
		.sync_o(pins)
	);

	wire frame_n_s = pins[2];
	wire shift_clk_s = pins[1];
	wire data_s = pins[0];
	wire frame_fall = frame_n_d & ~frame_n_s;
	wire frame_rise = ~frame_n_d & frame_n_s;
	wire sclk_fall = shift_clk_d & ~shift_clk_s;
	wire sclk_rise = ~shift_clk_d & shift_clk_s;

	always @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			// Match the synchroniser's reset level so no false frame fall follows reset
			frame_n_d <= 1'b0;
			shift_clk_d <= 1'b0;
		end else begin
			frame_n_d <= frame_n_s;
			shift_clk_d <= shift_clk_s;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Frame state machine

	wire full_word = (bit_count == `DDSL_BITS_LAST);
	wire commit_full = (state == ST_SHIFT) & full_word & sclk_rise;
	wire commit_short = (state == ST_SHIFT) & frame_rise & (bit_count != 5'h00);
	wire commit = commit_full | commit_short;

	always @* begin
		next_state = state;
		case (state)
		ST_IDLE: begin
			if (frame_fall) begin
				next_state = ST_SHIFT;
			end
		end
		ST_SHIFT: begin
			if (frame_rise) begin
				next_state = ST_IDLE;
			end else if (commit_full) begin
				next_state = ST_WAIT;
			end
		end
		ST_WAIT: begin
			if (frame_rise) begin
				next_state = ST_IDLE;
			end
		end
		default: next_state = ST_IDLE;
		endcase
	end

	always @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			state <= ST_IDLE;
			shift_word <= 16'h0000;
			bit_count <= 5'h00;
		end else begin
			state <= next_state;
			if (state == ST_IDLE && frame_fall) begin
				bit_count <= 5'h00;
			end else if (state == ST_SHIFT && sclk_fall && !full_word) begin
				shift_word <= {shift_word[14:0], data_s};
				bit_count <= bit_count + 5'h01;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Word decode into latches

	// Short frame: bits received so far are aligned as the word's top bits
	wire [15:0] word = full_word ? shift_word :
		(shift_word << (5'h10 - bit_count));
	wire [1:0] target = {word[`DDSL_BIT_SEL_HI], word[`DDSL_BIT_SEL_LO]};
	wire [11:0] data12 = word[`DDSL_DATA_MSB:0];
	wire [9:0] code10 = data12[`DDSL_DATA_MSB:`DDSL_CODE_LSB];

	always @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			channel_a_out_o <= `DDSL_CODE_RESET;
			channel_b_out_o <= `DDSL_CODE_RESET;
			hold_code <= `DDSL_CODE_RESET;
			vref_sel_hi_o <= 1'b0;
			vref_sel_lo_o <= 1'b0;
			speed_sel_o <= 1'b0;
			powerdown_sel_o <= 1'b0;
			word_done_o <= 1'b0;
		end else begin
			word_done_o <= commit;
			if (commit) begin
				speed_sel_o <= word[`DDSL_BIT_SPEED];
				powerdown_sel_o <= word[`DDSL_BIT_PDOWN];
				case (target)
				`DDSL_SEL_B_BUF: begin
					channel_b_out_o <= code10;
					hold_code <= code10;
				end
				`DDSL_SEL_BUF: begin
					hold_code <= code10;
				end
				`DDSL_SEL_A_UPD: begin
					channel_a_out_o <= code10;
					channel_b_out_o <= hold_code;
				end
				`DDSL_SEL_CTRL: begin
					vref_sel_hi_o <= data12[`DDSL_VREF_HI];
					vref_sel_lo_o <= data12[`DDSL_VREF_LO];
				end
				default: begin
					hold_code <= hold_code;
				end
				endcase
			end
		end
	end

	// Short-frame flag and word counter for software
	always @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			frame_err <= 1'b0;
			word_count <= 8'h00;
		end else begin
			if (commit_short) begin
				frame_err <= 1'b1;
			end else if (soft_clear) begin
				frame_err <= 1'b0;
			end
			if (commit) begin
				word_count <= word_count + 8'h01;
			end else if (soft_clear) begin
				word_count <= 8'h00;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave

	wire [31:0] status_word = {16'h0000, word_count, 1'b0, frame_err, state,
		speed_sel_o, powerdown_sel_o, vref_sel_hi_o, vref_sel_lo_o};
	reg aw_held;
	reg w_held;
	reg [3:0] aw_addr;
	reg [31:0] w_data;
	wire aw_take = s_axi_awvalid_i & s_axi_awready_o;
	wire w_take = s_axi_wvalid_i & s_axi_wready_o;
	wire [3:0] wr_addr = aw_take ? s_axi_awaddr_i : aw_addr;
	wire [31:0] wr_data = w_take ? s_axi_wdata_i : w_data;
	wire wr_go = (aw_held | aw_take) & (w_held | w_take) & ~s_axi_bvalid_o;

	always @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			s_axi_awready_o <= 1'b1;
			s_axi_wready_o <= 1'b1;
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o <= 2'b00;
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 4'h0;
			w_data <= `DDSL_CMD_RESET;
			soft_clear <= 1'b0;
		end else begin
			soft_clear <= 1'b0;
			if (aw_take) begin
				aw_addr <= s_axi_awaddr_i;
			end
			if (w_take) begin
				w_data <= s_axi_wdata_i;
			end
			if (wr_go) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_awready_o <= 1'b0;
				s_axi_wready_o <= 1'b0;
				s_axi_bvalid_o <= 1'b1;
				if (wr_addr == `DDSL_ADDR_STATUS) begin
					s_axi_bresp_o <= 2'b00;
					soft_clear <= wr_data[0] & s_axi_wstrb_i[0];
				end else if (ddsl_addr_ok(wr_addr) && wr_addr <= `DDSL_ADDR_HOLD) begin
					s_axi_bresp_o <= 2'b00;
				end else begin
					s_axi_bresp_o <= 2'b10;
				end
			end else begin
				if (aw_take) begin
					aw_held <= 1'b1;
					s_axi_awready_o <= 1'b0;
				end
				if (w_take) begin
					w_held <= 1'b1;
					s_axi_wready_o <= 1'b0;
				end
			end
			if (s_axi_bvalid_o && s_axi_bready_i) begin
				s_axi_bvalid_o <= 1'b0;
				s_axi_awready_o <= 1'b1;
				s_axi_wready_o <= 1'b1;
			end
		end
	end

	always @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			s_axi_arready_o <= 1'b1;
			s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o <= 32'h0000_0000;
			s_axi_rresp_o <= 2'b00;
		end else begin
			if (s_axi_arvalid_i && s_axi_arready_o) begin
				s_axi_arready_o <= 1'b0;
				s_axi_rvalid_o <= 1'b1;
				s_axi_rdata_o <= ddsl_read_mux(s_axi_araddr_i, channel_a_out_o,
					channel_b_out_o, hold_code, status_word);
				s_axi_rresp_o <= ddsl_addr_ok(s_axi_araddr_i) ? 2'b00 : 2'b10;
			end else if (s_axi_rvalid_o && s_axi_rready_i) begin
				s_axi_rvalid_o <= 1'b0;
				s_axi_arready_o <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

/* ddsl_consts.vh */
/*
 Constants for the dual DAC serial word loader: word fields, reference
 codes, reset values and frame counts.
 Assumes it is included by bare name from the loader sources.
*/
// Notes on behaviour
// - Frame select falling starts a frame; bits shift MSB first on shift-clock falls.
// - After 16 bits or frame select rising, word moves to its target latch.
// - Word is 16 bits: select hi, speed, power-down, select lo, twelve data bits.
// - Select 00 writes channel B and holding buffer; 01 writes holding buffer only.
// - Select 10 writes channel A and loads B from buffer; 11 writes control.
// - Control write uses only data bits 1 and 0 as reference selection.
// - Channel and buffer writes keep data bits 11 to 2, drop bits 1 and 0.
// - Twelve data bits are an unsigned code, 0x000 to 0xfff, divisor 0x1000.
// - Selected channel or buffer takes the word's data as its new value.
// - Reset clears both channel latches, holding buffer and control register.
// - Least significant bit is sampled on the 16th shift-clock fall of the frame.
// - Targets update on the 16th shift-clock rise without frame select rising.
// - Speed and power-down bits of each word drive speed and power control.
// - Reference bits: 00 external, 01 1.024 V, 10 2.048 V, 11 external.
// - Speed bit 1 selects fast settling, 0 slow settling.
// - Power-down bit 1 in any word puts the device in power-down.
`ifndef DDSL_CONSTS_VH
`define DDSL_CONSTS_VH

`define DDSL_WORD_BITS 16
`define DDSL_BIT_SEL_HI 15
`define DDSL_BIT_SPEED 14
`define DDSL_BIT_PDOWN 13
`define DDSL_BIT_SEL_LO 12
`define DDSL_DATA_MSB 11
`define DDSL_CODE_LSB 2
`define DDSL_VREF_HI 1
`define DDSL_VREF_LO 0

`define DDSL_SEL_B_BUF 2'b00
`define DDSL_SEL_BUF 2'b01
`define DDSL_SEL_A_UPD 2'b10
`define DDSL_SEL_CTRL 2'b11

`define DDSL_VREF_EXT0 2'b00
`define DDSL_VREF_1V024 2'b01
`define DDSL_VREF_2V048 2'b10
`define DDSL_VREF_EXT1 2'b11

`define DDSL_CODE_RESET 10'h000
`define DDSL_DATA_RESET 12'h000
`define DDSL_CTRL_RESET 2'h0
`define DDSL_FULL_SCALE 13'h1000
`define DDSL_BITS_LAST 5'h10

// AXI4-Lite register byte addresses
`define DDSL_ADDR_STATUS 4'h0
`define DDSL_ADDR_CHAN_A 4'h4
`define DDSL_ADDR_CHAN_B 4'h8
`define DDSL_ADDR_HOLD 4'hc
`define DDSL_CMD_RESET 32'h0000_0000

`endif

/* ddsl_sync.v */
/*
 Two-stage synchroniser for a vector of slow pin levels.
 Assumes the inputs are asynchronous to mclk_i.
*/
`timescale 1ns/1ps
`default_nettype none
module ddsl_sync #(
	parameter WIDTH = 3
) (
	input wire mclk_i,
	input wire rst_i,
	input wire [WIDTH-1:0] async_i,
	output reg [WIDTH-1:0] sync_o
);
	reg [WIDTH-1:0] stage;

	always @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			stage <= {WIDTH{1'b0}};
			sync_o <= {WIDTH{1'b0}};
		end else begin
			stage <= async_i;
			sync_o <= stage;
		end
	end
endmodule
`default_nettype wire

/* ddsl_host_model.sv */
/*
 Host serial controller model: frame select, shift clock and data pins.
 Assumes a free-running mclk_i; a shift-clock phase is ten of its cycles, the high phase before the ninth bit forty.
*/
`timescale 1ns/1ps
`default_nettype none
module ddsl_host_model (
	input wire logic mclk_i,
	output var logic frame_n_o,
	output var logic shift_clk_o,
	output var logic serial_data_o
);
	initial begin
		frame_n_o = 1'b1;
		shift_clk_o = 1'b1;
		serial_data_o = 1'b0;
	end

	task automatic half();
		repeat (10) @(posedge mclk_i);
	endtask

	// Positive extra adds pulses for the loader to ignore; negative cuts the frame short
	task automatic send(input logic [15:0] w, input int extra);
		frame_n_o <= 1'b0;
		for (int i = 0; i < 16 + extra; i++) begin
			if (i == 8)
				repeat (30) @(posedge mclk_i);
			serial_data_o <= (i < 16) ? w[15 - i] : i[0];
			half();
			shift_clk_o <= 1'b0;
			half();
			shift_clk_o <= 1'b1;
		end
		half();
		serial_data_o <= ~serial_data_o;
		frame_n_o <= 1'b1;
		repeat (3) half();
	endtask
endmodule
`default_nettype wire

/* ddsl_loader_monitor.sv */
/*
 Checker for the serial word loader, bound to its ports.
 Assumes one clock domain and the asynchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module ddsl_loader_monitor (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic frame_n_i,
	input wire logic shift_clk_i,
	input wire logic s_axi_arvalid_i,
	input wire logic s_axi_arready_o,
	input wire logic s_axi_rvalid_o,
	input wire logic [9:0] channel_a_out_o,
	input wire logic [9:0] channel_b_out_o,
	input wire logic speed_sel_o,
	input wire logic powerdown_sel_o,
	input wire logic vref_sel_hi_o,
	input wire logic vref_sel_lo_o,
	input wire logic word_done_o
);
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (rst_i);

	reset_clear_a: assert property ($fell(rst_i) |-> channel_a_out_o == 10'h000 &&
		channel_b_out_o == 10'h000 && !vref_sel_hi_o && !vref_sel_lo_o)
		else $error("latches not clear after reset");
	chan_a_commit_a: assert property ((channel_a_out_o != $past(channel_a_out_o))
		|-> word_done_o)
		else $error("channel A changed outside a commit");
	chan_b_commit_a: assert property ((channel_b_out_o != $past(channel_b_out_o))
		|-> word_done_o)
		else $error("channel B changed outside a commit");
	vref_commit_a: assert property ($changed({vref_sel_hi_o, vref_sel_lo_o})
		|-> word_done_o)
		else $error("reference changed outside a commit");
	mode_commit_a: assert property ($changed({speed_sel_o, powerdown_sel_o})
		|-> word_done_o)
		else $error("mode changed outside a commit");
	done_pulse_a: assert property (word_done_o |=> !word_done_o)
		else $error("done longer than one cycle");
	commit_edge_a: assert property (word_done_o |->
		(shift_clk_i && $past(shift_clk_i, 3) && !$past(shift_clk_i, 4) && !frame_n_i) ||
		($past(frame_n_i, 3) && !$past(frame_n_i, 4)))
		else $error("commit not on a shift-clock or frame rise");
	read_answer_a: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
		else $error("read data late");
endmodule

bind ddsl_loader ddsl_loader_monitor mon (.*);
`default_nettype wire

/* dual_dac_serial_word_loader_test.sv */
/*
 Testbench for the serial word loader: words from the host model, latches
 checked at the pins and over AXI4-Lite. Assumes the host model and checker.
*/
`timescale 1ns/1ps
`default_nettype none
module dual_dac_serial_word_loader_test;
	logic mclk_i = 1'b0;
	logic rst_i = 1'b1;
	wire frame_n_i;
	wire shift_clk_i;
	wire serial_data_i;
	logic [3:0] s_axi_awaddr_i = 4'h0;
	logic [3:0] s_axi_araddr_i = 4'h0;
	logic [3:0] s_axi_wstrb_i = 4'hf;
	logic [31:0] s_axi_wdata_i = 32'h0;
	logic s_axi_awvalid_i = 1'b0;
	logic s_axi_wvalid_i = 1'b0;
	logic s_axi_arvalid_i = 1'b0;
	logic s_axi_bready_i = 1'b1;
	logic s_axi_rready_i = 1'b1;
	logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
	logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
	logic [31:0] s_axi_rdata_o;
	logic [9:0] channel_a_out_o, channel_b_out_o;
	logic speed_sel_o, powerdown_sel_o, vref_sel_hi_o, vref_sel_lo_o, word_done_o;
	int num_errors = 0;
	int cmp_count = 0;
	int done_count = 0;
	logic [31:0] rd;
	logic [1:0] rs;
	logic [9:0] ea = 10'h000;
	logic [9:0] eb = 10'h000;
	logic [9:0] eh = 10'h000;
	logic [15:0] w [5] = '{16'h7abc, 16'h0123, 16'h1fff, 16'h85a7, 16'hc003};

	always #4 mclk_i = ~mclk_i;

	always @(posedge mclk_i) begin
		if (!rst_i && word_done_o)
			done_count++;
	end

	ddsl_loader uut (.*);
	ddsl_host_model host (
		.mclk_i(mclk_i),
		.frame_n_o(frame_n_i),
		.shift_clk_o(shift_clk_i),
		.serial_data_o(serial_data_i)
	);

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw = 1'b0;
		logic wt = 1'b0;
		s_axi_awaddr_i <= a;
		s_axi_wdata_i <= d;
		s_axi_awvalid_i <= 1'b1;
		s_axi_wvalid_i <= 1'b1;
		while (!(aw && wt)) begin
			@(posedge mclk_i);
			if (s_axi_awready_o) begin
				aw = 1'b1;
				s_axi_awvalid_i <= 1'b0;
			end
			if (s_axi_wready_o) begin
				wt = 1'b1;
				s_axi_wvalid_i <= 1'b0;
			end
		end
		do @(posedge mclk_i); while (!s_axi_bvalid_o);
		r = s_axi_bresp_o;
	endtask

	task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		s_axi_araddr_i <= a;
		s_axi_arvalid_i <= 1'b1;
		do @(posedge mclk_i); while (!s_axi_arready_o);
		s_axi_arvalid_i <= 1'b0;
		do @(posedge mclk_i); while (!s_axi_rvalid_o);
		d = s_axi_rdata_o;
		r = s_axi_rresp_o;
	endtask

	task automatic summarize();
		$display("Comparisons %0d, errors %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge mclk_i);
		num_errors++;
		summarize();
	end

	initial begin
		repeat (5) @(posedge mclk_i);
		rst_i <= 1'b0;
		repeat (3) @(posedge mclk_i);
		chk({channel_a_out_o, channel_b_out_o, speed_sel_o, powerdown_sel_o}, 32'h0);
		axi_rd(4'hc, rd, rs);
		chk(rd, 32'h0);
		for (int r = 0; r < 4; r++) begin
			host.send({1'b1, r[0], r[1], 1'b1, 10'h2aa, r[1:0]}, 0);
			chk({vref_sel_hi_o, vref_sel_lo_o}, r[1:0]);
			chk({speed_sel_o, powerdown_sel_o}, {r[0], r[1]});
			chk(channel_a_out_o, 32'h0);
		end
		for (int i = 0; i < 5; i++) begin
			host.send(w[i], (i == 1) ? 4 : 0);
			case ({w[i][15], w[i][12]})
				2'b00: begin
					eb = w[i][11:2];
					eh = w[i][11:2];
				end
				2'b01: eh = w[i][11:2];
				default: begin
					ea = w[i][11:2];
					eb = eh;
				end
			endcase
			chk({channel_a_out_o, channel_b_out_o}, {ea, eb});
			chk({speed_sel_o, powerdown_sel_o}, {w[i][14], w[i][13]});
			axi_rd(4'hc, rd, rs);
			chk(rd, eh);
		end
		// Ten bits then frame select rises: word left-aligned, low bits zero
		host.send(16'h12c0, -6);
		eh = 10'h0b0;
		chk({channel_a_out_o, channel_b_out_o}, {ea, eb});
		chk({speed_sel_o, powerdown_sel_o}, 2'b00);
		axi_rd(4'hc, rd, rs);
		chk(rd, eh);
		axi_rd(4'h0, rd, rs);
		chk(rd[15:6], {8'h0a, 2'b01});
		chk(done_count, 32'h0000_000a);
		axi_wr(4'h0, 32'h1, rs);
		chk(rs, 2'b00);
		axi_rd(4'h0, rd, rs);
		chk(rd[15:6], 10'h000);
		axi_wr(4'h4, 32'h3ff, rs);
		axi_rd(4'h4, rd, rs);
		chk(rd, ea);
		axi_rd(4'h2, rd, rs);
		chk(rs, 2'b10);
		axi_wr(4'h6, 32'h0, rs);
		chk(rs, 2'b10);
		summarize();
	end
endmodule
`default_nettype wire
